// file: hdl/tes_consts.vh
/*
 * constants for the 212 kbit/s edge shaper and power regulation config:
 * register indices, byte addresses, field positions, style codes, resets.
 * assumes inclusion by bare name from files of the tes block.
 */
`ifndef TES_CONSTS_VH
`define TES_CONSTS_VH

// ============================================================
// register indices and apb byte addresses (index times four)
`define TES_IDX_SHAPE_TYPE      8'h49
`define TES_IDX_SHAPE_OPTION    8'h4A
`define TES_IDX_SHAPE_LENGTH    8'h4B
`define TES_IDX_PWR_ENABLES     8'h68
`define TES_IDX_STATUS          8'h40
`define TES_ADDR_SHAPE_TYPE     12'h124
`define TES_ADDR_SHAPE_OPTION   12'h128
`define TES_ADDR_SHAPE_LENGTH   12'h12C
`define TES_ADDR_PWR_ENABLES    12'h1A0
`define TES_ADDR_STATUS         12'h100
`define TES_ADDR_W              12

// ============================================================
// reset values
`define TES_RST_SHAPE_TYPE      8'h11
`define TES_RST_SHAPE_OPTION    8'h00
`define TES_RST_SHAPE_LENGTH    8'h08
`define TES_RST_PWR_ENABLES     8'h00

// ============================================================
// field positions
`define TES_TYPE_FALL_HI        7
`define TES_TYPE_FALL_LO        4
`define TES_TYPE_RISE_HI        3
`define TES_TYPE_RISE_LO        0
`define TES_OPT_FALL_HI         6
`define TES_OPT_FALL_LO         4
`define TES_OPT_RISE_HI         2
`define TES_OPT_RISE_LO         0
`define TES_OPT_MASK            8'h77
`define TES_LEN_STRETCH_BIT     7
`define TES_LEN_COUNT_HI        4
`define TES_LEN_COUNT_LO        0
`define TES_LEN_MASK            8'h9F
`define TES_PWR_TARGET_BIT      2
`define TES_PWR_INIT_BIT        1
`define TES_PWR_READER_BIT      0
`define TES_PWR_MASK            8'h07

// ============================================================
// edge style codes
`define TES_STYLE_LIN1          4'h1
`define TES_STYLE_LIN2          4'h2
`define TES_STYLE_LIN3          4'h3
`define TES_STYLE_LUT_FIXED     4'h4
`define TES_STYLE_LUT_ADAPT_COR 4'h5
`define TES_STYLE_LUT_ADAPT     4'h6

// ============================================================
// rf modes and carrier divider
`define TES_MODE_READER         2'h0
`define TES_MODE_ACT_INIT       2'h1
`define TES_MODE_ACT_TARGET     2'h2
`define TES_CARRIER_DIV         18

`endif

// file: hdl/tes_edge_seq.v
/*
 * one edge sequencer: walks the transition states of a single modulation
 * edge on carrier ticks. assumes tick is a one-cycle enable at carrier
 * rate and that the config inputs are stable when start pulses.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tes_consts.vh"

module tes_edge_seq (
    // clock and reset
    input  wire       pclk,
    input  wire       presetn,
    // control
    input  wire       tick,
    input  wire       start,
    input  wire [3:0] style,
    input  wire [2:0] option,
    input  wire [4:0] n_states,
    input  wire       stretch,
    // shaping state
    output reg        busy_r,
    output reg        done_r,
    output reg  [4:0] state_r,
    output reg  [1:0] seg_r,
    output reg  [2:0] time_const_r,
    output reg  [1:0] lut_sel_r,
    output reg        lut_mode_r,
    output reg        lut_adapt_r,
    output reg        lut_correct_r
);

    // ============================================================
    // style decode
    function valid_style;
        input [3:0] s;
        begin
            valid_style = (s >= `TES_STYLE_LIN1) &&
                          (s <= `TES_STYLE_LUT_ADAPT);
        end
    endfunction

    reg [1:0] nramp_r;
    reg [4:0] count_r;
    reg       stretch_r;
    reg       half_r;
    reg [5:0] acc_r;
    wire [5:0] acc_sum = acc_r + {4'h0, nramp_r};
    wire       last = (state_r == count_r - 5'h01);

    // ============================================================
    // sequencer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_r        <= 1'b0;
            done_r        <= 1'b0;
            state_r       <= 5'h00;
            seg_r         <= 2'h0;
            time_const_r  <= 3'h0;
            lut_sel_r     <= 2'h0;
            lut_mode_r    <= 1'b0;
            lut_adapt_r   <= 1'b0;
            lut_correct_r <= 1'b0;
            nramp_r       <= 2'h0;
            count_r       <= 5'h00;
            stretch_r     <= 1'b0;
            half_r        <= 1'b0;
            acc_r         <= 6'h00;
        end else begin
            done_r <= 1'b0;
            if (start && !busy_r) begin
                state_r   <= 5'h00;
                seg_r     <= 2'h0;
                acc_r     <= 6'h00;
                half_r    <= 1'b0;
                count_r   <= n_states;
                stretch_r <= stretch;
                // reserved code or no states: edge passes unshaped
                if (valid_style(style) && n_states != 5'h00) begin
                    busy_r <= 1'b1;
                end else begin
                    done_r <= 1'b1;
                end
                if (style <= `TES_STYLE_LIN3) begin
                    nramp_r      <= style[1:0];
                    lut_mode_r   <= 1'b0;
                    time_const_r <= option;
                    lut_sel_r    <= 2'h0;
                end else begin
                    nramp_r      <= 2'h1;
                    lut_mode_r   <= valid_style(style);
                    time_const_r <= 3'h0;
                    lut_sel_r    <= option[1:0];
                end
                lut_adapt_r   <= (style == `TES_STYLE_LUT_ADAPT_COR) ||
                                 (style == `TES_STYLE_LUT_ADAPT);
                lut_correct_r <= (style == `TES_STYLE_LUT_ADAPT_COR);
            end else if (busy_r && tick) begin
                if (stretch_r && !half_r) begin
                    half_r <= 1'b1;
                end else begin
                    half_r <= 1'b0;
                    if (last) begin
                        busy_r <= 1'b0;
                        done_r <= 1'b1;
                    end else begin
                        state_r <= state_r + 5'h01;
                        // spread the ramps evenly over the states
                        if (acc_sum >= {1'b0, count_r}) begin
                            acc_r <= acc_sum - {1'b0, count_r};
                            if (seg_r != nramp_r - 2'h1)
                                seg_r <= seg_r + 2'h1;
                        end else begin
                            acc_r <= acc_sum;
                        end
                    end
                end
            end
        end
    end

endmodule

`default_nettype wire

// file: hdl/tes_pwr_reg_ctrl.v
/*
 * dynamic power regulation sequencing: one regulation run before each
 * transmission and after each rx_end seen while idle and without tx_req, if the current mode enables it.
 * assumes reg_done pulses once for every reg_start.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tes_consts.vh"

module tes_pwr_reg_ctrl (
    // clock and reset
    input  wire       pclk,
    input  wire       presetn,
    // mode and enables
    input  wire [1:0] rf_mode,
    input  wire [2:0] enables,
    // rf events
    input  wire       tx_req,
    input  wire       rx_end,
    input  wire       reg_done,
    // results
    output reg        reg_start_r,
    output reg        tx_go_r,
    output wire       busy
);

    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_PRE  = 2'h1;
    localparam [1:0] ST_POST = 2'h2;

    reg [1:0] state_r;
    reg       en;

    // ============================================================
    // per-mode enable
    always @* begin
        case (rf_mode)
            `TES_MODE_READER:     en = enables[`TES_PWR_READER_BIT];
            `TES_MODE_ACT_INIT:   en = enables[`TES_PWR_INIT_BIT];
            `TES_MODE_ACT_TARGET: en = enables[`TES_PWR_TARGET_BIT];
            default:              en = 1'b0;
        endcase
    end

    assign busy = (state_r != ST_IDLE);

    // ============================================================
    // sequence
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r     <= ST_IDLE;
            reg_start_r <= 1'b0;
            tx_go_r     <= 1'b0;
        end else begin
            reg_start_r <= 1'b0;
            tx_go_r     <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (tx_req) begin
                        if (en) begin
                            reg_start_r <= 1'b1;
                            state_r     <= ST_PRE;
                        end else begin
                            tx_go_r <= 1'b1;
                        end
                    end else if (rx_end && en) begin
                        reg_start_r <= 1'b1;
                        state_r     <= ST_POST;
                    end
                end
                ST_PRE: begin
                    // transmission held until regulation settles
                    if (reg_done) begin
                        tx_go_r <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
                ST_POST: begin
                    if (reg_done)
                        state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

endmodule

`default_nettype wire

// file: hdl/tes_top.v
/*
 * tx edge shaping and power regulation configuration, 212 kbit/s.
 * apb slave holding the config registers, a carrier tick divider, two
 * edge sequencers (falling, rising) and the regulation sequencer.
 * assumes a single pclk domain and synchronous rf event inputs.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tes_consts.vh"

module tes_top #(
    parameter CARRIER_DIV = `TES_CARRIER_DIV
) (
    // clock and reset
    input  wire                   pclk,
    input  wire                   presetn,
    // apb slave
    input  wire                   psel,
    input  wire                   penable,
    input  wire                   pwrite,
    input  wire [`TES_ADDR_W-1:0] paddr,
    input  wire [31:0]            pwdata,
    input  wire [3:0]             pstrb,
    output wire                   pready,
    output wire                   pslverr,
    output wire [31:0]            prdata,
    // modulation edge requests
    input  wire                   mod_fall_req,
    input  wire                   mod_rise_req,
    // rf events for power regulation
    input  wire [1:0]             rf_mode,
    input  wire                   tx_req,
    input  wire                   rx_end,
    input  wire                   reg_done,
    // edge shaping state, index 0 falling, 1 rising
    output wire                   carrier_tick,
    output wire [1:0]             edge_busy,
    output wire [1:0]             edge_done,
    output wire [9:0]             edge_state,
    output wire [3:0]             edge_seg,
    output wire [5:0]             edge_time_const,
    output wire [3:0]             edge_lut_sel,
    output wire [1:0]             edge_lut_mode,
    output wire [1:0]             edge_lut_adapt,
    output wire [1:0]             edge_lut_correct,
    // power regulation
    output wire                   reg_start,
    output wire                   tx_go,
    output wire                   reg_busy
);

    // ============================================================
    // registers
    reg  [7:0]  shape_type_r;
    reg  [7:0]  shape_option_r;
    reg  [7:0]  shape_length_r;
    reg  [7:0]  pwr_enables_r;
    reg  [31:0] rdata_r;
    reg         slverr_r;

    // ============================================================
    // apb decode
    function [2:0] addr_sel;
        input [`TES_ADDR_W-1:0] a;
        begin
            if (a == `TES_ADDR_SHAPE_TYPE)
                addr_sel = 3'h1;
            else if (a == `TES_ADDR_SHAPE_OPTION)
                addr_sel = 3'h2;
            else if (a == `TES_ADDR_SHAPE_LENGTH)
                addr_sel = 3'h3;
            else if (a == `TES_ADDR_PWR_ENABLES)
                addr_sel = 3'h4;
            else if (a == `TES_ADDR_STATUS)
                addr_sel = 3'h5;
            else
                addr_sel = 3'h0;
        end
    endfunction

    wire [2:0] sel     = addr_sel(paddr);
    wire       access  = psel && penable;
    wire       wr_en   = access && pwrite && pstrb[0];
    wire       setup   = psel && !penable;

    // zero wait state: answer in the access cycle itself
    assign pready  = 1'b1;
    assign pslverr = slverr_r;
    assign prdata  = rdata_r;

    // ============================================================
    // config register writes, reserved bits kept at zero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shape_type_r   <= `TES_RST_SHAPE_TYPE;
            shape_option_r <= `TES_RST_SHAPE_OPTION;
            shape_length_r <= `TES_RST_SHAPE_LENGTH;
            pwr_enables_r  <= `TES_RST_PWR_ENABLES;
        end else if (wr_en) begin
            if (sel == 3'h1)
                shape_type_r <= pwdata[7:0];
            else if (sel == 3'h2)
                shape_option_r <= pwdata[7:0] & `TES_OPT_MASK;
            else if (sel == 3'h3)
                shape_length_r <= pwdata[7:0] & `TES_LEN_MASK;
            else if (sel == 3'h4)
                pwr_enables_r <= pwdata[7:0] & `TES_PWR_MASK;
        end
    end

    // ============================================================
    // read data and error, registered in the setup cycle
    wire [7:0] status_byte = {5'h00, reg_busy, edge_busy};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r  <= 32'h00000000;
            slverr_r <= 1'b0;
        end else if (setup) begin
            slverr_r <= (sel == 3'h0) || (pwrite && sel == 3'h5);
            if (pwrite)
                rdata_r <= 32'h00000000;
            else if (sel == 3'h1)
                rdata_r <= {24'h000000, shape_type_r};
            else if (sel == 3'h2)
                rdata_r <= {24'h000000, shape_option_r};
            else if (sel == 3'h3)
                rdata_r <= {24'h000000, shape_length_r};
            else if (sel == 3'h4)
                rdata_r <= {24'h000000, pwr_enables_r};
            else if (sel == 3'h5)
                rdata_r <= {24'h000000, status_byte};
            else
                rdata_r <= 32'h00000000;
        end else if (!psel) begin
            rdata_r  <= 32'h00000000;
            slverr_r <= 1'b0;
        end
    end

    // ============================================================
    // carrier tick divider
    // the tick is a one-pclk pulse every CARRIER_DIV pclk cycles, a fixed
    // period with no jitter; the shaper only counts ticks.
    reg [7:0] div_r;
    reg       tick_r;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r  <= 8'h00;
            tick_r <= 1'b0;
        end else if (div_r == CARRIER_DIV[7:0] - 8'h01) begin
            div_r  <= 8'h00;
            tick_r <= 1'b1;
        end else begin
            div_r  <= div_r + 8'h01;
            tick_r <= 1'b0;
        end
    end

    assign carrier_tick = tick_r;

    // ============================================================
    // edge sequencers
    wire [7:0] edge_style_code_212 = {
        shape_type_r[`TES_TYPE_FALL_HI:`TES_TYPE_FALL_LO],
        shape_type_r[`TES_TYPE_RISE_HI:`TES_TYPE_RISE_LO]};
    wire [1:0] edge_start = {mod_rise_req, mod_fall_req};

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_edge
            tes_edge_seq u_seq (
                .pclk          (pclk),
                .presetn       (presetn),
                .tick          (tick_r),
                .start         (edge_start[g]),
                .style         (edge_style_code_212[7-4*g -: 4]),
                .option        (shape_option_r[6-4*g -: 3]),
                .n_states      (shape_length_r[`TES_LEN_COUNT_HI:
                                               `TES_LEN_COUNT_LO]),
                .stretch       (shape_length_r[`TES_LEN_STRETCH_BIT]),
                .busy_r        (edge_busy[g]),
                .done_r        (edge_done[g]),
                .state_r       (edge_state[5*g +: 5]),
                .seg_r         (edge_seg[2*g +: 2]),
                .time_const_r  (edge_time_const[3*g +: 3]),
                .lut_sel_r     (edge_lut_sel[2*g +: 2]),
                .lut_mode_r    (edge_lut_mode[g]),
                .lut_adapt_r   (edge_lut_adapt[g]),
                .lut_correct_r (edge_lut_correct[g])
            );
        end
    endgenerate

    // ============================================================
    // dynamic power regulation
    tes_pwr_reg_ctrl u_pwr (
        .pclk        (pclk),
        .presetn     (presetn),
        .rf_mode     (rf_mode),
        .enables     (pwr_enables_r[2:0]),
        .tx_req      (tx_req),
        .rx_end      (rx_end),
        .reg_done    (reg_done),
        .reg_start_r (reg_start),
        .tx_go_r     (tx_go),
        .busy        (reg_busy)
    );

endmodule

`default_nettype wire

// file: sim/tes_chk.sv
/* checker for tes_top: apb answers, edge sequencing, regulation pulses.
   assumes a bind onto tes_top and a single pclk domain. */
`timescale 1ns/1ps
`default_nettype none
`include "tes_consts.vh"
module tes_chk #(
    parameter int CARRIER_DIV = 18
) (
    // clock, reset, apb
    input wire logic        pclk, presetn, psel, penable, pwrite, pslverr,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    // edges and regulation
    input wire logic        mod_fall_req, mod_rise_req, tx_req, rx_end,
    input wire logic        reg_done, carrier_tick, reg_start, tx_go, reg_busy,
    input wire logic [1:0]  edge_busy, edge_done, edge_lut_mode,
    input wire logic [1:0]  edge_lut_adapt, edge_lut_correct,
    input wire logic [9:0]  edge_state,
    input wire logic [3:0]  edge_lut_sel,
    input wire logic [5:0]  edge_time_const
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_req_idle;
        (tx_req || rx_end) && !reg_busy;
    endsequence
    // ============================================================
    // apb
    AST_UNMAPPED: assert property (
        psel && penable && !(paddr inside {`TES_ADDR_SHAPE_TYPE,
        `TES_ADDR_SHAPE_OPTION, `TES_ADDR_SHAPE_LENGTH, `TES_ADDR_PWR_ENABLES,
        `TES_ADDR_STATUS}) |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    // ============================================================
    // edges
    AST_TICK_PERIOD: assert property (
        carrier_tick |-> ##CARRIER_DIV carrier_tick)
        else $error("carrier tick period wrong");
    AST_FALL_START: assert property (
        $rose(edge_busy[0]) |-> $past(mod_fall_req) && edge_state[4:0] == 5'h00)
        else $error("falling edge start wrong");
    AST_RISE_START: assert property (
        $rose(edge_busy[1]) |-> $past(mod_rise_req) && edge_state[9:5] == 5'h00)
        else $error("rising edge start wrong");
    AST_STATE_ON_TICK: assert property (
        edge_busy[0] && $past(edge_busy[0]) && $changed(edge_state[4:0])
        |-> $past(carrier_tick))
        else $error("state moved without carrier tick");
    AST_DONE_AT_END: assert property (
        $fell(edge_busy[0]) |-> edge_done[0])
        else $error("edge ended without done");
    AST_LUT_NO_TC: assert property (
        edge_busy[0] && edge_lut_mode[0] |-> edge_time_const[2:0] == 3'h0)
        else $error("table style carries time constant");
    AST_LIN_NO_SEL: assert property (
        edge_busy[0] && !edge_lut_mode[0] |-> edge_lut_sel[1:0] == 2'h0)
        else $error("linear style carries table select");
    AST_CORR_ADAPT: assert property (
        edge_busy[0] && edge_lut_correct[0] |-> edge_lut_adapt[0])
        else $error("correction without adaptation");
    AST_REG_START_CAUSE: assert property (
        reg_start |-> $past((tx_req || rx_end) && !reg_busy))
        else $error("regulation start without event");
    AST_REG_HELD: assert property (
        s_req_idle ##1 reg_start |-> reg_busy && !tx_go)
        else $error("transmit not held during regulation");
    AST_TX_GO_CAUSE: assert property (
        tx_go |-> $past(reg_done && reg_busy) || $past(tx_req && !reg_busy))
        else $error("transmit go without cause");
endmodule
bind tes_top tes_chk #(.CARRIER_DIV(CARRIER_DIV)) chk_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pslverr(pslverr), .paddr(paddr), .prdata(prdata),
    .mod_fall_req(mod_fall_req), .mod_rise_req(mod_rise_req),
    .tx_req(tx_req), .rx_end(rx_end), .reg_done(reg_done),
    .carrier_tick(carrier_tick), .reg_start(reg_start), .tx_go(tx_go),
    .reg_busy(reg_busy), .edge_busy(edge_busy), .edge_done(edge_done),
    .edge_lut_mode(edge_lut_mode), .edge_lut_adapt(edge_lut_adapt),
    .edge_lut_correct(edge_lut_correct), .edge_state(edge_state),
    .edge_lut_sel(edge_lut_sel), .edge_time_const(edge_time_const));
`default_nettype wire

// file: sim/tx_edge_shaping_and_power_ctrl_cfg_tb_top.sv
/* self-checking bench for tes_top: registers, both edges, regulation.
   assumes tes_top and the checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
`include "tes_consts.vh"
module tx_edge_shaping_and_power_ctrl_cfg_tb_top;
    // short carrier divider keeps edge runs brief
    localparam int DIV = 3;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic [3:0]  pstrb = 0;
    logic        mod_fall_req = 0, mod_rise_req = 0, tx_req = 0;
    logic        rx_end = 0, reg_done = 0;
    logic [1:0]  rf_mode = 0;
    wire logic   pready, pslverr, carrier_tick, reg_start, tx_go, reg_busy;
    wire logic [31:0] prdata;
    wire logic [1:0]  edge_busy, edge_done, e_mode, e_adapt, e_corr;
    wire logic [9:0]  edge_state;
    wire logic [3:0]  edge_seg, e_sel;
    wire logic [5:0]  e_tc;
    int          err_total = 0, total_checks = 0;
    int          tk[2] = '{0, 0};
    logic [9:0]  rd_q[$];
    logic [17:0] edge_q[2][$];
    tes_top #(.CARRIER_DIV(DIV)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .mod_fall_req(mod_fall_req),
        .mod_rise_req(mod_rise_req), .rf_mode(rf_mode), .tx_req(tx_req),
        .rx_end(rx_end), .reg_done(reg_done), .carrier_tick(carrier_tick),
        .edge_busy(edge_busy), .edge_done(edge_done), .edge_state(edge_state),
        .edge_seg(edge_seg), .edge_time_const(e_tc), .edge_lut_sel(e_sel),
        .edge_lut_mode(e_mode), .edge_lut_adapt(e_adapt),
        .edge_lut_correct(e_corr), .reg_start(reg_start), .tx_go(tx_go),
        .reg_busy(reg_busy));
    initial forever #2 pclk = ~pclk;
    task automatic check(input string nm, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ============================================================
    // apb master: note expectation, setup, access until pready
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [7:0] d, input logic err, input logic [7:0] x);
        rd_q.push_back({wr, err, x});
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'($urandom()), d};
        pstrb <= {3'($urandom()), 1'b1};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // style code, option and length give latched config and tick count
    function automatic logic [17:0] edge_exp(input logic [3:0] c,
                                             input logic [2:0] o,
                                             input logic [7:0] l);
        logic v, lut;
        v = c >= 4'h1 && c <= 4'h6 && l[4:0] != 5'h00;
        lut = c >= 4'h4;
        return {v, v ? {2'h0, l[4:0]} << l[7] : 7'h00,
                lut ? 2'h0 : c[1:0] - 2'h1, lut, c >= 4'h5,
                c == 4'h5, lut ? o[1:0] : 2'h0, lut ? 3'h0 : o};
    endfunction
    task automatic reg_run(input logic tx);
        repeat ($urandom_range(1, 4)) @(posedge pclk);
        reg_done <= 1'b1;
        @(posedge pclk);
        reg_done <= 1'b0;
        #1 check("tx_go", tx, tx_go);
    endtask
    // ============================================================
    // result watcher: oldest note against what appears
    always @(posedge pclk) begin
        logic [9:0]  r;
        logic [17:0] e;
        if (psel && penable && pready) begin
            r = rd_q.pop_front();
            check("pslverr", r[8], pslverr);
            if (!r[9]) check("prdata", {24'h0, r[7:0]}, prdata);
        end
        for (int i = 0; i < 2; i++) begin
            if (edge_busy[i] && carrier_tick) tk[i]++;
            if (edge_done[i]) begin
                e = edge_q[i].pop_front();
                check("ticks", e[16:10], tk[i]);
                if (e[17]) check("edge_cfg", e[9:0], {edge_seg[2*i+:2],
                    e_mode[i], e_adapt[i], e_corr[i], e_sel[2*i+:2],
                    e_tc[3*i+:3]});
                tk[i] = 0;
            end
        end
    end
    initial begin
        #(20000 * 4);
        err_total++;
        give_verdict();
    end
    initial begin
        logic [11:0] ra[4];
        logic [7:0]  rv[4], mk[4], o, l;
        logic [3:0]  f, r;
        logic        en;
        int          n;
        ra = '{`TES_ADDR_SHAPE_TYPE, `TES_ADDR_SHAPE_OPTION,
               `TES_ADDR_SHAPE_LENGTH, `TES_ADDR_PWR_ENABLES};
        rv = '{`TES_RST_SHAPE_TYPE, `TES_RST_SHAPE_OPTION,
               `TES_RST_SHAPE_LENGTH, `TES_RST_PWR_ENABLES};
        mk = '{8'hFF, 8'h77, 8'h9F, 8'h07};
        void'($urandom(74));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            apb(0, ra[i], 8'h00, 0, rv[i]);
            apb(1, ra[i], 8'hFF, 0, 8'h00);
            apb(0, ra[i], 8'h00, 0, mk[i]);
        end
        apb(0, 12'h004, 8'h00, 1, 8'h00);
        apb(1, `TES_ADDR_STATUS, 8'hFF, 1, 8'h00);
        apb(0, `TES_ADDR_STATUS, 8'h00, 0, 8'h00);
        // every style code on each edge, count boundaries 31 and 0
        for (int k = 0; k < 8; k++) begin
            f = 4'(k);
            r = 4'((k + 3) % 8);
            o = 8'($urandom()) & 8'h77;
            l = {1'($urandom()), 2'h0, 5'($urandom_range(3, 8))};
            if (k == 2) l[4:0] = 5'h1F;
            if (k == 4) l[4:0] = 5'h00;
            apb(1, `TES_ADDR_SHAPE_TYPE, {f, r}, 0, 8'h00);
            apb(1, `TES_ADDR_SHAPE_OPTION, o, 0, 8'h00);
            apb(1, `TES_ADDR_SHAPE_LENGTH, l, 0, 8'h00);
            edge_q[0].push_back(edge_exp(f, o[6:4], l));
            edge_q[1].push_back(edge_exp(r, o[2:0], l));
            @(posedge pclk);
            mod_fall_req <= 1'b1;
            mod_rise_req <= 1'b1;
            @(posedge pclk);
            mod_fall_req <= 1'b0;
            mod_rise_req <= 1'b0;
            n = 0;
            while ((edge_q[0].size() + edge_q[1].size()) != 0 && n++ < 600)
                @(posedge pclk);
            check("edge_left", 0, edge_q[0].size() + edge_q[1].size());
        end
        // every enable pattern against every mode
        for (int e = 0; e < 8; e++) begin
            apb(1, `TES_ADDR_PWR_ENABLES, 8'(e), 0, 8'h00);
            for (int m = 0; m < 4; m++) begin
                rf_mode <= 2'(m);
                en = m < 3 && e[m];
                @(posedge pclk);
                tx_req <= 1'b1;
                @(posedge pclk);
                tx_req <= 1'b0;
                #1 check("reg_start", en, reg_start);
                check("tx_go", !en, tx_go);
                if (en) reg_run(1);
                @(posedge pclk);
                rx_end <= 1'b1;
                @(posedge pclk);
                rx_end <= 1'b0;
                #1 check("reg_start", en, reg_start);
                if (en) reg_run(0);
            end
        end
        give_verdict();
    end
endmodule
`default_nettype wire
